/* rtl/epb_regs.vh */
// Constants of the external parallel bus port
//
// Overview of operation
// RULE1: Drive address as master, take it as slave
// RULE2: 32-bit words ride data lines 47 to 16
// RULE3: 40-bit words ride data lines 47 to 8
// RULE4: Short words ride data lines 31 to 16
// RULE5: Boot bytes ride data lines 23 to 16
// RULE6: Four bank selects decoded from address, configured size
// RULE7: Selects idle without access, asserted for conditionals
// RULE8: Read strobe driven as master, sensed as slave
// RULE9: Write strobe driven as master, sensed as slave
// RULE10: Page signal on DRAM page boundary crossing
// RULE11: Page signal only for bank 0 accesses
// RULE12: Early write select, abandoned without write strobe
// RULE13: Write select asserted with the address
// RULE14: Slave tells reads from writes by select
// RULE15: Master waits while acknowledge is low
// RULE16: Slave drives acknowledge low for wait states
// RULE17: Master keeps last acknowledge level in keeper
// RULE18: Only bus master drives selects, strobes, clock
// RULE19: Address, selects, strobes, page, clock float as slave or suspended
// RULE20: Inputs pass a two-stage synchroniser first
// RULE21: Unused data lanes ignored on reads
`ifndef EPB_REGS_VH
`define EPB_REGS_VH

// ====================================================
// Word formats
`define EPB_FMT_W32 2'h0
`define EPB_FMT_W40 2'h1
`define EPB_FMT_W16 2'h2
`define EPB_FMT_BYTE 2'h3

// ====================================================
// Address map and timing
`define EPB_EXT_BASE 32'h0040_0000
`define EPB_INT_AW 8
`define EPB_SLV_WAIT 3'h2
`define EPB_ACK_LAT 2'h3

`endif

/* rtl/epb_port.v */
// External parallel bus port: master engine, slave engine, response buffer
`timescale 1ns/100ps
`include "epb_regs.vh"

module epb_port (
   input wire clk_sys,
   input wire rst,
   input wire bus_master,
   input wire [4:0] bank_size_log2,
   input wire [4:0] page_size_log2,
   input wire [1:0] slave_fmt,
   input wire core_req_valid,
   output wire core_req_ready,
   input wire core_req_write,
   input wire core_req_cond,
   input wire [1:0] core_req_fmt,
   input wire [31:0] core_req_addr,
   input wire [39:0] core_req_wdata,
   output wire rsp_valid,
   input wire rsp_ready,
   output wire [39:0] rsp_data,
   input wire [31:0] addr_i,
   output reg [31:0] addr_o,
   output wire addr_oe,
   input wire [47:0] data_i,
   output reg [47:0] data_o,
   output reg data_oe,
   output reg [3:0] bank_select_n,
   output wire bank_select_oe,
   input wire rd_n_i,
   output reg rd_n_o,
   output wire rd_n_oe,
   input wire wr_n_i,
   output reg wr_n_o,
   output wire wr_n_oe,
   output reg page_o,
   output wire page_oe,
   input wire sync_write_sel_n_i,
   output reg sync_write_sel_n_o,
   output wire sync_write_sel_n_oe,
   input wire ack_i,
   output reg ack_o,
   output reg ack_oe,
   output reg bus_ref_clock_out,
   output wire bus_ref_clock_oe,
   input wire bus_suspend_n
);

   localparam M_IDLE = 2'h0;
   localparam M_ADDR = 2'h1;
   localparam M_STRB = 2'h2;
   localparam M_END = 2'h3;
   localparam S_IDLE = 2'h0;
   localparam S_WAIT = 2'h1;
   localparam S_DONE = 2'h2;
   localparam S_HOLD = 2'h3;

   // ====================================================
   // Input synchronisers
   reg [4:0] ctl_s1_q;
   reg [4:0] ctl_s2_q;
   reg [31:0] addr_s1_q;
   reg [31:0] addr_s2_q;
   reg [47:0] data_s1_q;
   reg [47:0] data_s2_q;
   wire ack_s;
   wire rd_s_n;
   wire wr_s_n;
   wire sw_s_n;
   wire susp_s_n;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl_s1_q <= 5'h1f;
         ctl_s2_q <= 5'h1f;
         addr_s1_q <= 32'h0000_0000;
         addr_s2_q <= 32'h0000_0000;
         data_s1_q <= 48'h0000_0000_0000;
         data_s2_q <= 48'h0000_0000_0000;
      end else begin
         ctl_s1_q <= {ack_i, rd_n_i, wr_n_i, sync_write_sel_n_i, bus_suspend_n}; // RULE20
         ctl_s2_q <= ctl_s1_q;
         addr_s1_q <= addr_i;
         addr_s2_q <= addr_s1_q;
         data_s1_q <= data_i;
         data_s2_q <= data_s1_q;
      end
   end

   assign ack_s = ctl_s2_q[4];
   assign rd_s_n = ctl_s2_q[3];
   assign wr_s_n = ctl_s2_q[2];
   assign sw_s_n = ctl_s2_q[1];
   assign susp_s_n = ctl_s2_q[0];

   // ====================================================
   // Output enables and reference clock
   wire drive_en;
   assign drive_en = bus_master & susp_s_n; // RULE19
   assign addr_oe = drive_en; // RULE1
   assign bank_select_oe = drive_en; // RULE18
   assign rd_n_oe = drive_en;
   assign wr_n_oe = drive_en;
   assign page_oe = drive_en;
   assign sync_write_sel_n_oe = drive_en;
   assign bus_ref_clock_oe = drive_en;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_ref_clock_out <= 1'b0;
      end else begin
         bus_ref_clock_out <= ~bus_ref_clock_out;
      end
   end

   // ====================================================
   // Acknowledge keeper
   reg ack_keep_q;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_keep_q <= 1'b1;
      end else begin
         ack_keep_q <= ack_s; // RULE17
      end
   end

   // ====================================================
   // Two-entry response buffer
   reg [39:0] buf_mem [0:1];
   reg [1:0] buf_cnt_q;
   reg buf_wp_q;
   reg buf_rp_q;
   reg buf_push;
   reg [39:0] buf_wdata;
   wire buf_pop;

   assign rsp_valid = (buf_cnt_q != 2'h0);
   assign rsp_data = buf_mem[buf_rp_q];
   assign buf_pop = rsp_valid & rsp_ready;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         buf_cnt_q <= 2'h0;
         buf_wp_q <= 1'b0;
         buf_rp_q <= 1'b0;
         buf_mem[0] <= 40'h00_0000_0000;
         buf_mem[1] <= 40'h00_0000_0000;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wp_q] <= buf_wdata;
            buf_wp_q <= ~buf_wp_q;
         end
         if (buf_pop) begin
            buf_rp_q <= ~buf_rp_q;
         end
         if (buf_push & ~buf_pop) begin
            buf_cnt_q <= buf_cnt_q + 2'h1;
         end else if (buf_pop & ~buf_push) begin
            buf_cnt_q <= buf_cnt_q - 2'h1;
         end
      end
   end

   // ====================================================
   // Lane placement
   function [47:0] lane_put;
      input [1:0] fmt;
      input [39:0] w;
      begin
         case (fmt)
            `EPB_FMT_W32: lane_put = {w[31:0], 16'h0000}; // RULE2
            `EPB_FMT_W40: lane_put = {w, 8'h00}; // RULE3
            `EPB_FMT_W16: lane_put = {16'h0000, w[15:0], 16'h0000}; // RULE4
            default: lane_put = {24'h00_0000, w[7:0], 16'h0000}; // RULE5
         endcase
      end
   endfunction

   function [39:0] lane_get;
      input [1:0] fmt;
      input [47:0] d;
      begin
         case (fmt)
            `EPB_FMT_W32: lane_get = {8'h00, d[47:16]}; // RULE21
            `EPB_FMT_W40: lane_get = d[47:8];
            `EPB_FMT_W16: lane_get = {24'h00_0000, d[31:16]};
            default: lane_get = {32'h0000_0000, d[23:16]};
         endcase
      end
   endfunction

   // ====================================================
   // Bank decode and page detection
   wire [31:0] ext_off;
   wire [31:0] bank_idx;
   wire [3:0] bank_dec_n;
   wire [31:0] page_diff;
   wire page_cross;
   reg [31:0] last_b0_q;
   reg last_b0_vld_q;

   assign ext_off = core_req_addr - `EPB_EXT_BASE;
   assign bank_idx = ext_off >> bank_size_log2;
   assign bank_dec_n = (core_req_addr < `EPB_EXT_BASE || bank_idx > 32'h3) ? 4'hf :
      ~(4'h1 << bank_idx[1:0]); // RULE6
   assign page_diff = (core_req_addr ^ last_b0_q) >> page_size_log2;
   assign page_cross = ~bank_dec_n[0] & (~last_b0_vld_q | (page_diff != 32'h0)); // RULE10 RULE11

   // ====================================================
   // Master engine
   reg [1:0] m_state_q;
   reg m_wr_q;
   reg m_cond_q;
   reg [1:0] m_fmt_q;
   wire m_can_start;
   reg [1:0] m_age_q;
   wire m_done;

   // Ack path lags the strobe by three flops
   assign m_done = (m_age_q == `EPB_ACK_LAT) & ack_keep_q & susp_s_n; // RULE15 RULE17

   assign m_can_start = drive_en & (m_state_q == M_IDLE) &
      (core_req_write | ~core_req_cond | (buf_cnt_q != 2'h2));
   assign core_req_ready = m_can_start;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m_state_q <= M_IDLE;
         m_wr_q <= 1'b0;
         m_cond_q <= 1'b0;
         m_age_q <= 2'h0;
         m_fmt_q <= `EPB_FMT_W32;
         addr_o <= 32'h0000_0000;
         bank_select_n <= 4'hf;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         page_o <= 1'b0;
         sync_write_sel_n_o <= 1'b1;
         last_b0_q <= 32'h0000_0000;
         last_b0_vld_q <= 1'b0;
      end else begin
         case (m_state_q)
            M_IDLE: begin
               bank_select_n <= 4'hf; // RULE7
               page_o <= 1'b0;
               if (core_req_valid & m_can_start) begin
                  addr_o <= core_req_addr; // RULE1
                  bank_select_n <= bank_dec_n; // RULE6 RULE7
                  page_o <= page_cross;
                  sync_write_sel_n_o <= ~core_req_write; // RULE12 RULE13
                  m_wr_q <= core_req_write;
                  m_cond_q <= core_req_cond;
                  m_fmt_q <= core_req_fmt;
                  if (~bank_dec_n[0]) begin
                     last_b0_q <= core_req_addr;
                     last_b0_vld_q <= 1'b1;
                  end
                  m_state_q <= M_ADDR;
               end
            end
            M_ADDR: begin
               if (susp_s_n) begin
                  if (m_cond_q) begin
                     rd_n_o <= m_wr_q; // RULE8
                     m_age_q <= 2'h0;
                     wr_n_o <= ~m_wr_q; // RULE9
                     m_state_q <= M_STRB;
                  end else begin
                     m_state_q <= M_END; // RULE12
                  end
               end
            end
            M_STRB: begin
               if (m_age_q != `EPB_ACK_LAT) begin
                  m_age_q <= m_age_q + 2'h1;
               end
               if (m_done) begin // RULE15
                  rd_n_o <= 1'b1;
                  wr_n_o <= 1'b1;
                  m_state_q <= M_END;
               end
            end
            M_END: begin
               sync_write_sel_n_o <= 1'b1;
               bank_select_n <= 4'hf;
               page_o <= 1'b0;
               m_state_q <= M_IDLE;
            end
            default: m_state_q <= M_IDLE;
         endcase
      end
   end

   // ====================================================
   // Slave engine and internal memory
   reg [39:0] int_mem [0:(1 << `EPB_INT_AW) - 1];
   reg [1:0] s_state_q;
   reg [2:0] s_cnt_q;
   reg s_wr_q;
   reg [`EPB_INT_AW-1:0] s_addr_q;
   reg [39:0] core_req_wdata_q;
   wire s_hit;

   assign s_hit = ~bus_master & (addr_s2_q[31:`EPB_INT_AW] == 0) & (~rd_s_n | ~wr_s_n); // RULE1 RULE8 RULE9

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_state_q <= S_IDLE;
         s_cnt_q <= 3'h0;
         s_wr_q <= 1'b0;
         s_addr_q <= {`EPB_INT_AW{1'b0}};
         ack_o <= 1'b1;
         ack_oe <= 1'b0;
         data_o <= 48'h0000_0000_0000;
         data_oe <= 1'b0;
      end else begin
         data_oe <= 1'b0;
         if (drive_en & (m_state_q == M_STRB) & m_wr_q) begin
            data_o <= lane_put(m_fmt_q, core_req_wdata_q);
            data_oe <= 1'b1;
         end
         case (s_state_q)
            S_IDLE: begin
               ack_oe <= 1'b0;
               if (s_hit) begin
                  s_wr_q <= ~sw_s_n | ~wr_s_n; // RULE14
                  s_addr_q <= addr_s2_q[`EPB_INT_AW-1:0];
                  s_cnt_q <= `EPB_SLV_WAIT;
                  ack_o <= 1'b0; // RULE16
                  ack_oe <= 1'b1;
                  s_state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (s_cnt_q == 3'h0) begin
                  ack_o <= 1'b1;
                  s_state_q <= S_DONE;
               end else begin
                  s_cnt_q <= s_cnt_q - 3'h1;
               end
            end
            S_DONE: begin
               ack_oe <= 1'b0;
               if (s_wr_q & ~wr_s_n) begin
                  int_mem[s_addr_q] <= lane_get(slave_fmt, data_s2_q);
               end
               s_state_q <= S_HOLD;
            end
            S_HOLD: begin
               ack_oe <= 1'b0;
               if (rd_s_n & wr_s_n) begin
                  s_state_q <= S_IDLE;
               end
            end
            default: s_state_q <= S_IDLE;
         endcase
         if (~bus_master & ~s_wr_q & (s_state_q != S_IDLE) & ~rd_s_n) begin
            data_o <= lane_put(slave_fmt, int_mem[s_addr_q]);
            data_oe <= 1'b1;
         end
      end
   end

   // ====================================================
   // Write data hold and read capture
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_req_wdata_q <= 40'h00_0000_0000;
      end else if (core_req_valid & m_can_start) begin
         core_req_wdata_q <= core_req_wdata;
      end
   end

   always @* begin
      buf_push = (m_state_q == M_STRB) & ~m_wr_q & m_done;
      buf_wdata = lane_get(m_fmt_q, data_s2_q); // RULE21
   end

endmodule // epb_port

/* tb/epb_mem_model.sv */
// External memory model with wait states
`timescale 1ns/100ps
module epb_mem_model (
   input wire clk_sys,
   input wire [31:0] addr_o,
   input wire rd_n_o,
   input wire wr_n_o,
   input wire [47:0] data_o,
   output wire ack_i,
   output wire [47:0] data_i
);
   reg [47:0] mem [0:15];
   reg [47:0] junk_q = 48'h0;
   integer cnt = 0, waits = 0, n_wr = 0;
   wire idle = rd_n_o & wr_n_o;
   assign ack_i = idle | (cnt >= waits);
   assign data_i = rd_n_o ? junk_q : mem[addr_o[3:0]];
   always @(posedge clk_sys) begin
      junk_q <= ~junk_q ^ 48'h5a;
      cnt <= idle ? 0 : cnt + 1;
      if (!wr_n_o && cnt == 0)
         n_wr <= n_wr + 1;
      if (!wr_n_o && ack_i)
         mem[addr_o[3:0]] <= data_o;
   end
endmodule // epb_mem_model

/* tb/epb_port_asserts.sv */
// Concurrent checks on the external bus port pins
`timescale 1ns/100ps
`include "epb_regs.vh"
module epb_port_asserts (
   input wire clk_sys,
   input wire rst,
   input wire bus_master,
   input wire [4:0] bank_size_log2,
   input wire core_req_valid,
   input wire core_req_ready,
   input wire core_req_write,
   input wire [31:0] core_req_addr,
   input wire [31:0] addr_o,
   input wire addr_oe,
   input wire [3:0] bank_select_n,
   input wire bank_select_oe,
   input wire rd_n_o,
   input wire rd_n_oe,
   input wire wr_n_o,
   input wire wr_n_oe,
   input wire page_o,
   input wire page_oe,
   input wire sync_write_sel_n_o,
   input wire sync_write_sel_n_oe,
   input wire ack_i,
   input wire ack_o,
   input wire ack_oe,
   input wire bus_ref_clock_out,
   input wire bus_ref_clock_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_float; !bus_master |-> !(addr_oe | bank_select_oe | rd_n_oe | wr_n_oe | page_oe
      | sync_write_sel_n_oe | bus_ref_clock_oe); endproperty
   a_float: assert property (p_float) else $error("driven as slave");
   property p_sw_addr; $fell(sync_write_sel_n_o) |-> $past(core_req_valid && core_req_ready && core_req_write)
      && addr_o == $past(core_req_addr); endproperty
   a_sw_addr: assert property (p_sw_addr) else $error("write select not with address");
   property p_sel_dec; bank_select_n != 4'hf |->
      bank_select_n == ~(4'h1 << ((addr_o - `EPB_EXT_BASE) >> bank_size_log2)); endproperty
   a_sel_dec: assert property (p_sel_dec) else $error("bank decode wrong");
   property p_page_bank; $rose(page_o) |-> !bank_select_n[0]; endproperty
   a_page_bank: assert property (p_page_bank) else $error("page outside bank 0");
   property p_wr_sw; $fell(wr_n_o) |-> !sync_write_sel_n_o && !$past(sync_write_sel_n_o); endproperty
   a_wr_sw: assert property (p_wr_sw) else $error("write without early select");
   property p_rd_sw; $fell(rd_n_o) |-> sync_write_sel_n_o && $stable(bank_select_n); endproperty
   a_rd_sw: assert property (p_rd_sw) else $error("read with write select");
   property p_wait; !rd_n_o && !ack_i |=> !rd_n_o; endproperty
   a_wait: assert property (p_wait) else $error("read ended in wait");
   property p_slv_ack; $rose(ack_oe) |-> !ack_o [*3] ##1 ack_o ##1 !ack_oe; endproperty
   a_slv_ack: assert property (p_slv_ack) else $error("slave wait sequence wrong");
   property p_refclk; 1'b1 |=> bus_ref_clock_out != $past(bus_ref_clock_out); endproperty
   a_refclk: assert property (p_refclk) else $error("reference clock stalled");
endmodule // epb_port_asserts

/* tb/epb_port_tb_top.sv */
// Testbench of the external bus port
`timescale 1ns/100ps
`include "epb_regs.vh"
module epb_port_tb_top;
   reg clk_sys, rst, bus_master, bus_suspend_n, core_req_valid, core_req_write, core_req_cond, rsp_ready;
   reg s_rd_n, s_wr_n, s_sw_n, pg_q;
   reg [4:0] bank_size_log2, page_size_log2;
   reg [1:0] slave_fmt, core_req_fmt;
   reg [31:0] core_req_addr, s_addr;
   reg [39:0] core_req_wdata;
   reg [47:0] s_data;
   reg [3:0] sel_q;
   integer n_mismatch = 0, samples_checked = 0, cyc = 0, i, j;
   wire core_req_ready, rsp_valid, addr_oe, data_oe, bank_select_oe, rd_n_o, rd_n_oe, wr_n_o, wr_n_oe, page_o;
   wire page_oe, sync_write_sel_n_o, sync_write_sel_n_oe, ack_o, ack_oe, bus_ref_clock_out, bus_ref_clock_oe, m_ack;
   wire [3:0] bank_select_n;
   wire [31:0] addr_o;
   wire [39:0] rsp_data;
   wire [47:0] data_o, m_data;
   wire [31:0] addr_i = addr_oe ? addr_o : s_addr;
   wire [47:0] data_i = data_oe ? data_o : bus_master ? m_data : s_data;
   wire rd_n_i = rd_n_oe ? rd_n_o : s_rd_n;
   wire wr_n_i = wr_n_oe ? wr_n_o : s_wr_n;
   wire sync_write_sel_n_i = sync_write_sel_n_oe ? sync_write_sel_n_o : s_sw_n;
   wire ack_i = ack_oe ? ack_o : m_ack;
   epb_port i_dut (.clk_sys(clk_sys), .rst(rst), .bus_master(bus_master), .bank_size_log2(bank_size_log2),
      .page_size_log2(page_size_log2), .slave_fmt(slave_fmt), .core_req_valid(core_req_valid),
      .core_req_ready(core_req_ready), .core_req_write(core_req_write), .core_req_cond(core_req_cond),
      .core_req_fmt(core_req_fmt), .core_req_addr(core_req_addr), .core_req_wdata(core_req_wdata),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .addr_i(addr_i), .addr_o(addr_o),
      .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .bank_select_n(bank_select_n),
      .bank_select_oe(bank_select_oe), .rd_n_i(rd_n_i), .rd_n_o(rd_n_o), .rd_n_oe(rd_n_oe), .wr_n_i(wr_n_i),
      .wr_n_o(wr_n_o), .wr_n_oe(wr_n_oe), .page_o(page_o), .page_oe(page_oe),
      .sync_write_sel_n_i(sync_write_sel_n_i), .sync_write_sel_n_o(sync_write_sel_n_o),
      .sync_write_sel_n_oe(sync_write_sel_n_oe), .ack_i(ack_i), .ack_o(ack_o), .ack_oe(ack_oe),
      .bus_ref_clock_out(bus_ref_clock_out), .bus_ref_clock_oe(bus_ref_clock_oe), .bus_suspend_n(bus_suspend_n));
   epb_mem_model i_mem (.clk_sys(clk_sys), .addr_o(addr_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .data_o(data_o),
      .ack_i(m_ack), .data_i(m_data));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task chk(input [47:0] g, e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task results;
      begin
         $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         n_mismatch = n_mismatch + 1;
         results;
      end
   end
   task acc(input wr, cd, input [1:0] f, input [31:0] a, input [39:0] w);
      begin
         {core_req_write, core_req_cond, core_req_fmt, core_req_addr, core_req_wdata} = {wr, cd, f, a, w};
         core_req_valid = 1'b1;
         for (i = 0; i < 50 && core_req_ready !== 1'b1; i = i + 1)
            @(negedge clk_sys);
         @(negedge clk_sys);
         core_req_valid = 1'b0;
         @(negedge clk_sys);
         {sel_q, pg_q} = {bank_select_n, page_o};
         for (i = 0; i < 50 && bank_select_n !== 4'hf; i = i + 1)
            @(negedge clk_sys);
         @(negedge clk_sys);
      end
   endtask
   task rsp(input [47:0] e);
      begin
         for (i = 0; i < 50 && rsp_valid !== 1'b1; i = i + 1)
            @(negedge clk_sys);
         chk(rsp_data, e);
         rsp_ready = 1'b1;
         @(negedge clk_sys);
         rsp_ready = 1'b0;
         @(negedge clk_sys);
      end
   endtask
   task t_fmt(input [1:0] f, input [47:0] er, ew);
      begin
         i_mem.waits = f;
         i_mem.mem[f] = 48'ha5c3_9e17_6b2d;
         acc(0, 1, f, `EPB_EXT_BASE + f, 40'h0);
         rsp(er);
         acc(1, 1, f, `EPB_EXT_BASE + 8 + f, 40'h9b_8642_1357);
         chk(i_mem.mem[8 + f], ew);
         $display("%0t format test done", $time);
      end
   endtask
   task t_cond;
      begin
         j = i_mem.n_wr;
         acc(1, 0, 0, `EPB_EXT_BASE, 40'h1);
         chk(sel_q, 4'he);
         chk(i_mem.n_wr, j);
         acc(0, 0, 0, `EPB_EXT_BASE, 40'h0);
         repeat (8) @(negedge clk_sys);
         chk(rsp_valid, 0);
         $display("%0t conditional test done", $time);
      end
   endtask
   task t_page;
      begin
         acc(1, 1, 0, `EPB_EXT_BASE + 32'h40, 40'h0);
         chk(pg_q, 1);
         acc(1, 1, 0, `EPB_EXT_BASE + 32'h41, 40'h0);
         chk(pg_q, 0);
         for (j = 1; j < 4; j = j + 1) begin
            acc(1, 1, 0, `EPB_EXT_BASE + 32'h80 + (j << 8), 40'h0);
            chk({sel_q, pg_q}, {~(4'h1 << j), 1'b0});
         end
         $display("%0t page test done", $time);
      end
   endtask
   task t_buf;
      begin
         i_mem.mem[4] = 48'h1111_2222_3333;
         i_mem.mem[5] = 48'h4444_5555_6666;
         acc(0, 1, 0, `EPB_EXT_BASE + 4, 40'h0);
         acc(0, 1, 0, `EPB_EXT_BASE + 5, 40'h0);
         core_req_valid = 1'b1;
         repeat (3) @(negedge clk_sys);
         chk(core_req_ready, 0);
         core_req_valid = 1'b0;
         rsp(48'h1111_2222);
         rsp(48'h4444_5555);
         chk(rsp_valid, 0);
         $display("%0t buffer test done", $time);
      end
   endtask
   task t_slave;
      begin
         bus_master = 1'b0;
         {s_addr, s_data, s_sw_n, s_wr_n} = {32'h5, 48'h1234_5678_0000, 2'b00};
         @(negedge clk_sys);
         chk(addr_oe, 0);
         for (j = 0; j < 2; j = j + 1) begin
            for (i = 0; i < 50 && !(ack_oe === 1'b1 && ack_o === 1'b1); i = i + 1)
               @(negedge clk_sys);
            chk(ack_oe & ack_o, 1);
            if (j == 1)
               chk(data_o[47:16], 32'h1234_5678);
            {s_sw_n, s_wr_n, s_rd_n} = 3'b111;
            repeat (4) @(negedge clk_sys);
            if (j == 0)
               s_rd_n = 1'b0;
         end
         bus_master = 1'b1;
         $display("%0t slave test done", $time);
      end
   endtask
   task t_susp;
      begin
         bus_suspend_n = 1'b0;
         repeat (3) @(negedge clk_sys);
         chk({addr_oe, core_req_ready}, 0);
         bus_suspend_n = 1'b1;
         repeat (3) @(negedge clk_sys);
         chk(addr_oe, 1);
         $display("%0t suspend test done", $time);
      end
   endtask
   initial begin
      {rst, bus_master, bus_suspend_n, core_req_valid, core_req_write, core_req_cond, rsp_ready} = 7'h70;
      {s_rd_n, s_wr_n, s_sw_n} = 3'b111;
      {bank_size_log2, page_size_log2, slave_fmt, core_req_fmt} = {5'h8, 5'h4, 2'h0, 2'h0};
      {core_req_addr, s_addr, core_req_wdata, s_data} = 152'h0;
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      t_fmt(0, 48'ha5c3_9e17, 48'h8642_1357_0000);
      t_fmt(1, 48'ha5_c39e_176b, 48'h9b86_4213_5700);
      t_fmt(2, 48'h9e17, 48'h1357_0000);
      t_fmt(3, 48'h17, 48'h57_0000);
      t_cond;
      t_page;
      t_buf;
      t_susp;
      t_slave;
      results;
   end
endmodule // epb_port_tb_top
bind epb_port epb_port_asserts i_chk (.clk_sys(clk_sys), .rst(rst), .bus_master(bus_master),
   .bank_size_log2(bank_size_log2), .core_req_valid(core_req_valid), .core_req_ready(core_req_ready),
   .core_req_write(core_req_write), .core_req_addr(core_req_addr), .addr_o(addr_o), .addr_oe(addr_oe),
   .bank_select_n(bank_select_n), .bank_select_oe(bank_select_oe), .rd_n_o(rd_n_o), .rd_n_oe(rd_n_oe),
   .wr_n_o(wr_n_o), .wr_n_oe(wr_n_oe), .page_o(page_o), .page_oe(page_oe),
   .sync_write_sel_n_o(sync_write_sel_n_o), .sync_write_sel_n_oe(sync_write_sel_n_oe), .ack_i(ack_i),
   .ack_o(ack_o), .ack_oe(ack_oe), .bus_ref_clock_out(bus_ref_clock_out), .bus_ref_clock_oe(bus_ref_clock_oe));
